/* common/cdc_regs.vh */
// Register indices, reset values, field codes and bus addresses of the CD decoder control bank.
`ifndef CDC_REGS_VH
`define CDC_REGS_VH

// Register indices as written by the controller; the bus byte address is four times the index.
`define CDC_IDX_DAO 4'hA
`define CDC_IDX_SPEED 4'hB
`define CDC_IDX_PIN 4'hC
`define CDC_IDX_AUX 4'hD
`define CDC_IDX_MOTOR 4'hE
`define CDC_IDX_SUB 4'hF
`define CDC_IDX_FIRST 4'hA
`define CDC_NUM_REGS 6

// Power-on values of each register.
`define CDC_RST_DAO 4'h2
`define CDC_RST_SPEED 4'h0
`define CDC_RST_PIN 4'h2
`define CDC_RST_AUX 4'hF
`define CDC_RST_MOTOR 4'h4
`define CDC_RST_SUB 4'h0

// Bus map of the extra registers and the shadow readback window.
`define CDC_ADDR_ESCAPE 8'h40
`define CDC_ADDR_STATUS 8'h44
`define CDC_SHADOW_BIT 7
`define CDC_MAIN_LIMIT 8'h40

// Field codes.
`define CDC_SPD_STOP 3'h0
`define CDC_SPD_PAUSE 3'h2
`define CDC_SPD_OPER 3'h3
`define CDC_V4_MOTOR 4'h0
`define CDC_PINSEL_SIG 2'h1
`define CDC_PINSEL_LOW 2'h2
`define CDC_PINSEL_HIGH 2'h3
`define CDC_BANK_MAIN 2'h0

// Bus responses.
`define CDC_RESP_OKAY 2'h0
`define CDC_RESP_SLVERR 2'h2

`endif

/* hdl/cdc_ctrl_regs.v */
// CD decoder control register bank behind an AXI4-Lite slave, with pin steering.
//
// Summary of operation
// - speed register selects standby, operation and speed.
// - pattern X1X1 switches digital audio off, low.
// - versatile register picks off-track source, kill, pin three.
// - clear bit zero uses internal off-track; pin readable.
// - bit three picks soft or hard mute at single speed.
// - second register sets pin four function.
// - top bits set pin five, de-emphasis filter.
// - motor register sets braking, lock, features, quad.
// - bank 00 decodes main; subcode enable, format.
// - bank 01 sends later writes to bank one.
// - bank 10 sends later writes to bank two.
// - bank 11 sends later writes to bank three.
// - power-on reset loads each documented initial value.
`timescale 1ns/1ns
`include "cdc_regs.vh"
module cdc_ctrl_regs
(
  // Clock and reset.
  input wire CLK,
  input wire ARST_N,
  // AXI4-Lite write address and data.
  input wire AWVALID,
  output reg AWREADY,
  input wire [7:0] AWADDR,
  input wire [2:0] AWPROT,
  input wire WVALID,
  output reg WREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  // AXI4-Lite write response.
  output reg BVALID,
  input wire BREADY,
  output reg [1:0] BRESP,
  // AXI4-Lite read address and data.
  input wire ARVALID,
  output reg ARREADY,
  input wire [7:0] ARADDR,
  input wire [2:0] ARPROT,
  output reg RVALID,
  input wire RREADY,
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  // Signals from the decoder core and pins.
  input wire AUX1_IN,
  input wire OFFTRACK_INT,
  input wire DAO_DATA_IN,
  input wire QW_SUBCODE_IN,
  input wire DEEMPH_IN,
  input wire MOTOR_A_IN,
  input wire MOTOR_B_IN,
  // Digital audio output.
  output reg DAO_OUT,
  output reg DAO_FLAGS_EN,
  // Speed and standby state.
  output reg STOP_STANDBY,
  output reg PAUSE_STANDBY,
  output reg OPERATING,
  output reg DOUBLE_SPEED,
  output reg QUAD_SPEED,
  // Off-track, kill and mute.
  output reg OFFTRACK_OUT,
  output reg MONO_KILL,
  output reg HARD_MUTE,
  // Versatile pins.
  output reg AUX3_OUT,
  output reg AUX4_OUT,
  output reg AUX5_OUT,
  output reg MOTOR4_EN,
  output reg INT_DEEMPH_EN,
  // Motor and features.
  output reg BRAKE_6PCT,
  output reg LOCK_TO_DISC,
  output reg AUDIO_FEAT_EN,
  // Subcode and bank.
  output reg SUBCODE_EN,
  output reg SUBCODE_3WIRE,
  output reg [1:0] BANK_SEL
);

  // Read sequencer states.
  localparam [2:0] RD_IDLE = 3'b001;
  localparam [2:0] RD_WAIT = 3'b010;
  localparam [2:0] RD_RESP = 3'b100;

  // Reset value of the register at a given slot.
  function [3:0] reset_val;
    input integer slot;
    begin
      case (slot)
        0: reset_val = `CDC_RST_DAO;
        1: reset_val = `CDC_RST_SPEED;
        2: reset_val = `CDC_RST_PIN;
        3: reset_val = `CDC_RST_AUX;
        4: reset_val = `CDC_RST_MOTOR;
        default: reset_val = `CDC_RST_SUB;
      endcase
    end
  endfunction

  // Pin level for a two-bit select: signal, forced low or forced high.
  function pin_drive;
    input [1:0] sel;
    input sig;
    input hold;
    begin
      if (sel == `CDC_PINSEL_SIG)
        pin_drive = sig;
      else if (sel == `CDC_PINSEL_LOW)
        pin_drive = 1'b0;
      else if (sel == `CDC_PINSEL_HIGH)
        pin_drive = 1'b1;
      else
        pin_drive = hold;
    end
  endfunction

  reg aw_got_reg;
  reg w_got_reg;
  reg [7:0] aw_addr_reg;
  reg [3:0] w_data_reg;
  reg w_lane_reg;
  reg [2:0] rd_state_reg;
  reg [7:0] ar_addr_reg;
  reg [1:0] bank_reg;
  wire [23:0] main_bus;
  wire aw_take = AWVALID & AWREADY;
  wire w_take = WVALID & WREADY;
  wire aw_now = aw_got_reg | aw_take;
  wire w_now = w_got_reg | w_take;
  wire [7:0] wr_addr = aw_got_reg ? aw_addr_reg : AWADDR;
  wire [3:0] wr_nib = w_got_reg ? w_data_reg : WDATA[3:0];
  wire wr_lane = w_got_reg ? w_lane_reg : WSTRB[0];
  wire wr_fire = aw_now & w_now & ~BVALID;
  wire wr_word = (wr_addr[1:0] == 2'h0);
  wire wr_main = wr_word & (wr_addr < `CDC_MAIN_LIMIT);
  wire wr_escape = (wr_addr == `CDC_ADDR_ESCAPE);
  wire [3:0] wr_idx = wr_addr[5:2];
  wire wr_ok = wr_main | wr_escape;
  wire wr_in_shadow = wr_fire & wr_main & wr_lane & (bank_reg != `CDC_BANK_MAIN);
  wire wr_in_main = wr_fire & wr_main & wr_lane & (bank_reg == `CDC_BANK_MAIN);
  wire [3:0] mem_rd_data;

  // Address and data are taken in either order; both are held until the write fires.
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 4'h0;
      w_lane_reg <= 1'b0;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= `CDC_RESP_OKAY;
    end
    else
    begin
      if (wr_fire)
      begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= wr_ok ? `CDC_RESP_OKAY : `CDC_RESP_SLVERR;
        AWREADY <= 1'b0;
        WREADY <= 1'b0;
      end
      else
      begin
        if (aw_take)
        begin
          aw_got_reg <= 1'b1;
          aw_addr_reg <= AWADDR;
        end
        if (w_take)
        begin
          w_got_reg <= 1'b1;
          w_data_reg <= WDATA[3:0];
          w_lane_reg <= WSTRB[0];
        end
        if (BVALID & BREADY)
          BVALID <= 1'b0;
        // Ready stays low while a response is pending, so one write at a time.
        AWREADY <= ~aw_now & ~(BVALID & ~BREADY);
        WREADY <= ~w_now & ~(BVALID & ~BREADY);
      end
    end
  end

  // Main decoder registers; a write replaces the whole nibble, don't-care bits too.
  genvar gi;
  generate
    for (gi = 0; gi < `CDC_NUM_REGS; gi = gi + 1)
    begin : g_main
      reg [3:0] val_reg;
      always @(posedge CLK or negedge ARST_N)
      begin
        if (!ARST_N)
          val_reg <= reset_val(gi);
        else if (wr_in_main && (wr_idx == `CDC_IDX_FIRST + gi))
          val_reg <= wr_nib;
      end
      assign main_bus[4 * gi + 3:4 * gi] = val_reg;
    end
  endgenerate

  wire [3:0] dao_reg = main_bus[3:0];
  wire [3:0] speed_reg = main_bus[7:4];
  wire [3:0] pin_reg = main_bus[11:8];
  wire [3:0] aux_reg = main_bus[15:12];
  wire [3:0] motor_reg = main_bus[19:16];
  wire [3:0] sub_reg = main_bus[23:20];

  // Bank selection follows the subcode register; the escape address returns to the main bank.
  // Without the escape, software could never leave a shadow bank, since every later
  // address goes to that bank.
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      bank_reg <= `CDC_BANK_MAIN;
    else if (wr_fire & wr_escape)
      bank_reg <= `CDC_BANK_MAIN;
    else if (wr_in_main && (wr_idx == `CDC_IDX_SUB))
      bank_reg <= wr_nib[1:0];
  end

  // Shadow storage, addressed by bank and index; bank 01, 10 and 11 each own sixteen words.
  cdc_shadow_mem u_shadow
  (
    .clk(CLK),
    .wr_en(wr_in_shadow),
    .wr_addr({bank_reg, wr_idx}),
    .wr_data(wr_nib),
    .rd_addr({bank_reg, ARADDR[5:2]}), // Looked up at the take edge.
    .rd_data(mem_rd_data)
  );

  // Reads take two cycles so shadow data can leave the memory's output register.
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rd_state_reg <= RD_IDLE;
      ar_addr_reg <= 8'h00;
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= `CDC_RESP_OKAY;
    end
    else
    begin
      case (rd_state_reg)
        RD_IDLE:
        begin
          ARREADY <= ~(ARVALID & ARREADY);
          if (ARVALID & ARREADY)
          begin
            ar_addr_reg <= ARADDR;
            rd_state_reg <= RD_WAIT;
          end
        end
        RD_WAIT:
        begin
          RVALID <= 1'b1;
          rd_state_reg <= RD_RESP;
          RDATA <= 32'h00000000;
          RRESP <= `CDC_RESP_OKAY;
          // Main registers are write-only and read as zero.
          if (ar_addr_reg[1:0] != 2'h0)
            RRESP <= `CDC_RESP_SLVERR;
          else if (ar_addr_reg == `CDC_ADDR_STATUS)
            RDATA[7:0] <= {OPERATING, PAUSE_STANDBY, STOP_STANDBY, ~DAO_FLAGS_EN | DAO_OUT,
                           OFFTRACK_OUT, AUX1_IN, bank_reg};
          else if (ar_addr_reg[`CDC_SHADOW_BIT])
          begin
            if (bank_reg != `CDC_BANK_MAIN)
              RDATA[3:0] <= mem_rd_data;
          end
          else if (!((ar_addr_reg < `CDC_MAIN_LIMIT) || (ar_addr_reg == `CDC_ADDR_ESCAPE)))
            RRESP <= `CDC_RESP_SLVERR;
        end
        RD_RESP:
        begin
          if (RREADY)
          begin
            RVALID <= 1'b0;
            ARREADY <= 1'b1;
            rd_state_reg <= RD_IDLE;
          end
        end
        default:
        begin
          rd_state_reg <= RD_IDLE;
        end
      endcase
    end
  end

  reg stop_next;
  reg pause_next;
  reg oper_next;
  reg aux4_next;
  reg aux5_next;

  // Decode of standby mode and of the fourth and fifth versatile pins.
  always @*
  begin
    stop_next = 1'b0;
    pause_next = 1'b0;
    oper_next = 1'b0;
    // Undocumented low codes fall back to stop standby, the safest motor state.
    if (speed_reg[2:0] == `CDC_SPD_PAUSE)
      pause_next = 1'b1;
    else if (speed_reg[2:0] == `CDC_SPD_OPER)
      oper_next = 1'b1;
    else
      stop_next = 1'b1;
    if (aux_reg == `CDC_V4_MOTOR)
    begin
      aux4_next = MOTOR_A_IN;
      aux5_next = MOTOR_B_IN;
    end
    else
    begin
      aux4_next = pin_drive(aux_reg[1:0], QW_SUBCODE_IN, AUX4_OUT);
      aux5_next = pin_drive(aux_reg[3:2], DEEMPH_IN, AUX5_OUT);
    end
  end

  // All control outputs are registered copies of the decoded fields.
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      DAO_OUT <= 1'b0;
      DAO_FLAGS_EN <= 1'b0;
      STOP_STANDBY <= 1'b1;
      PAUSE_STANDBY <= 1'b0;
      OPERATING <= 1'b0;
      DOUBLE_SPEED <= 1'b0;
      QUAD_SPEED <= 1'b0;
      OFFTRACK_OUT <= 1'b0;
      MONO_KILL <= 1'b1;
      HARD_MUTE <= 1'b0;
      AUX3_OUT <= 1'b0;
      AUX4_OUT <= 1'b1;
      AUX5_OUT <= 1'b1;
      MOTOR4_EN <= 1'b0;
      INT_DEEMPH_EN <= 1'b1;
      BRAKE_6PCT <= 1'b0;
      LOCK_TO_DISC <= 1'b0;
      AUDIO_FEAT_EN <= 1'b1;
      SUBCODE_EN <= 1'b0;
      SUBCODE_3WIRE <= 1'b0;
      BANK_SEL <= `CDC_BANK_MAIN;
    end
    else
    begin
      DAO_OUT <= DAO_DATA_IN & ~(dao_reg[2] & dao_reg[0]);
      DAO_FLAGS_EN <= dao_reg[3];
      STOP_STANDBY <= stop_next;
      PAUSE_STANDBY <= pause_next;
      OPERATING <= oper_next;
      DOUBLE_SPEED <= speed_reg[3] & ~motor_reg[3];
      QUAD_SPEED <= motor_reg[3];
      OFFTRACK_OUT <= pin_reg[0] ? AUX1_IN : OFFTRACK_INT;
      MONO_KILL <= pin_reg[1];
      // Soft mute only works at single speed, so faster modes force hard mute.
      HARD_MUTE <= pin_reg[3] | speed_reg[3] | motor_reg[3];
      AUX3_OUT <= pin_reg[2];
      AUX4_OUT <= aux4_next;
      AUX5_OUT <= aux5_next;
      MOTOR4_EN <= (aux_reg == `CDC_V4_MOTOR);
      INT_DEEMPH_EN <= ~((aux_reg[3:2] == `CDC_PINSEL_SIG) & (aux_reg != `CDC_V4_MOTOR));
      BRAKE_6PCT <= motor_reg[0];
      LOCK_TO_DISC <= motor_reg[1];
      AUDIO_FEAT_EN <= motor_reg[2];
      SUBCODE_EN <= sub_reg[2];
      SUBCODE_3WIRE <= sub_reg[3];
      BANK_SEL <= bank_reg;
    end
  end

endmodule

/* hdl/cdc_shadow_mem.v */
// Shadow register storage: four banks of sixteen nibbles with a registered read port.
`timescale 1ns/1ns
module cdc_shadow_mem
(
  // Clock.
  input wire clk,
  // Write port.
  input wire wr_en,
  input wire [5:0] wr_addr,
  input wire [3:0] wr_data,
  // Read port.
  input wire [5:0] rd_addr,
  output reg [3:0] rd_data
);

  reg [3:0] mem [0:63];

  // No reset on the array so it maps onto plain RAM; reads of unwritten words are undefined.
  always @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

/* tb/cdc_ctrl_checker.sv */
// Concurrent checks on the ports of the control register bank.
`timescale 1ns/1ns
module cdc_ctrl_checker
(
  // Clock and reset.
  input logic CLK,
  input logic ARST_N,
  // Bus handshakes.
  input logic AWVALID,
  input logic AWREADY,
  input logic WVALID,
  input logic WREADY,
  input logic BVALID,
  input logic BREADY,
  input logic ARVALID,
  input logic ARREADY,
  input logic RVALID,
  // Pin inputs.
  input logic MOTOR_A_IN,
  input logic DEEMPH_IN,
  // Control outputs.
  input logic STOP_STANDBY,
  input logic PAUSE_STANDBY,
  input logic OPERATING,
  input logic DOUBLE_SPEED,
  input logic QUAD_SPEED,
  input logic HARD_MUTE,
  input logic AUX4_OUT,
  input logic AUX5_OUT,
  input logic MOTOR4_EN,
  input logic INT_DEEMPH_EN,
  input logic [1:0] BANK_SEL
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  // Exactly one standby or operating state is shown at a time.
  state_onehot_a: assert property ($onehot({STOP_STANDBY, PAUSE_STANDBY, OPERATING}))
    else $error("standby state outputs not one-hot");
  // Soft mute only exists at single speed, so faster modes must use hard mute.
  fast_mute_a: assert property ((DOUBLE_SPEED || QUAD_SPEED) |->
    HARD_MUTE && !(DOUBLE_SPEED && QUAD_SPEED)) else $error("fast mode without hard mute");
  motor_pin_a: assert property (MOTOR4_EN |-> AUX4_OUT == $past(MOTOR_A_IN))
    else $error("pin four not following motor drive");
  deemph_pin_a: assert property (!INT_DEEMPH_EN |->
    !MOTOR4_EN && AUX5_OUT == $past(DEEMPH_IN)) else $error("pin five not showing de-emphasis");
  write_resp_a: assert property (AWVALID && AWREADY && WVALID && WREADY |->
    ##[1:2] BVALID) else $error("write response missing");
  bresp_release_a: assert property ($fell(BVALID) |-> $past(BREADY))
    else $error("write response dropped early");
  read_resp_a: assert property (ARVALID && ARREADY |-> ##[1:3] RVALID)
    else $error("read response missing");
  // The bank only moves as a result of a completed write.
  bank_change_a: assert property ($changed(BANK_SEL) |->
    $past(BVALID) || $past(BVALID, 2) || $past(BVALID, 3)) else $error("bank moved without a write");
endmodule

bind cdc_ctrl_regs cdc_ctrl_checker chk_u (.CLK(CLK), .ARST_N(ARST_N), .AWVALID(AWVALID),
  .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY),
  .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .MOTOR_A_IN(MOTOR_A_IN),
  .DEEMPH_IN(DEEMPH_IN), .STOP_STANDBY(STOP_STANDBY), .PAUSE_STANDBY(PAUSE_STANDBY),
  .OPERATING(OPERATING), .DOUBLE_SPEED(DOUBLE_SPEED), .QUAD_SPEED(QUAD_SPEED),
  .HARD_MUTE(HARD_MUTE), .AUX4_OUT(AUX4_OUT), .AUX5_OUT(AUX5_OUT), .MOTOR4_EN(MOTOR4_EN),
  .INT_DEEMPH_EN(INT_DEEMPH_EN), .BANK_SEL(BANK_SEL));

/* tb/cdc_ctrl_regs_tb.sv */
// Self-checking bench for the control register bank.
`timescale 1ns/1ns
`include "cdc_regs.vh"
module cdc_ctrl_regs_tb;
  reg CLK = 1'h0;
  reg ARST_N = 1'h0;
  reg AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
  reg [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
  reg [31:0] WDATA = 32'h0;
  reg AUX1_IN = 1'h1, OFFTRACK_INT = 1'h0, DAO_DATA_IN = 1'h1, QW_SUBCODE_IN = 1'h0;
  reg DEEMPH_IN = 1'h1, MOTOR_A_IN = 1'h1, MOTOR_B_IN = 1'h0;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID, DAO_OUT, DAO_FLAGS_EN, STOP_STANDBY;
  wire PAUSE_STANDBY, OPERATING, DOUBLE_SPEED, QUAD_SPEED, OFFTRACK_OUT, MONO_KILL, HARD_MUTE;
  wire AUX3_OUT, AUX4_OUT, AUX5_OUT, MOTOR4_EN, INT_DEEMPH_EN, BRAKE_6PCT, LOCK_TO_DISC;
  wire AUDIO_FEAT_EN, SUBCODE_EN, SUBCODE_3WIRE;
  wire [1:0] BRESP, RRESP, BANK_SEL;
  wire [31:0] RDATA;
  integer errors = 0;
  integer num_checks = 0;
  integer i;
  reg [31:0] rd;

  cdc_ctrl_regs dut_u (.CLK(CLK), .ARST_N(ARST_N), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .AWADDR(AWADDR), .AWPROT(3'h0), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA),
    .WSTRB(4'hF), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .ARADDR(ARADDR), .ARPROT(3'h0), .RVALID(RVALID), .RREADY(RREADY),
    .RDATA(RDATA), .RRESP(RRESP), .AUX1_IN(AUX1_IN), .OFFTRACK_INT(OFFTRACK_INT),
    .DAO_DATA_IN(DAO_DATA_IN), .QW_SUBCODE_IN(QW_SUBCODE_IN), .DEEMPH_IN(DEEMPH_IN),
    .MOTOR_A_IN(MOTOR_A_IN), .MOTOR_B_IN(MOTOR_B_IN), .DAO_OUT(DAO_OUT),
    .DAO_FLAGS_EN(DAO_FLAGS_EN), .STOP_STANDBY(STOP_STANDBY), .PAUSE_STANDBY(PAUSE_STANDBY),
    .OPERATING(OPERATING), .DOUBLE_SPEED(DOUBLE_SPEED), .QUAD_SPEED(QUAD_SPEED),
    .OFFTRACK_OUT(OFFTRACK_OUT), .MONO_KILL(MONO_KILL), .HARD_MUTE(HARD_MUTE),
    .AUX3_OUT(AUX3_OUT), .AUX4_OUT(AUX4_OUT), .AUX5_OUT(AUX5_OUT), .MOTOR4_EN(MOTOR4_EN),
    .INT_DEEMPH_EN(INT_DEEMPH_EN), .BRAKE_6PCT(BRAKE_6PCT), .LOCK_TO_DISC(LOCK_TO_DISC),
    .AUDIO_FEAT_EN(AUDIO_FEAT_EN), .SUBCODE_EN(SUBCODE_EN), .SUBCODE_3WIRE(SUBCODE_3WIRE),
    .BANK_SEL(BANK_SEL));

  // A 40 ns period gives the 25 MHz system clock.
  always #20 CLK = ~CLK;

  // Collects the outputs steered by each register into one nibble.
  function [3:0] grp(input [3:0] k);
    case (k)
      4'hA: grp = {2'h0, DAO_FLAGS_EN, DAO_OUT};
      4'hB: grp = {DOUBLE_SPEED, OPERATING, PAUSE_STANDBY, STOP_STANDBY};
      4'hC: grp = {HARD_MUTE, AUX3_OUT, MONO_KILL, OFFTRACK_OUT};
      4'hD: grp = {MOTOR4_EN, INT_DEEMPH_EN, AUX5_OUT, AUX4_OUT};
      4'hE: grp = {QUAD_SPEED, AUDIO_FEAT_EN, LOCK_TO_DISC, BRAKE_6PCT};
      default: grp = {SUBCODE_3WIRE, SUBCODE_EN, BANK_SEL};
    endcase
  endfunction

  // Compares one value and counts the outcome.
  task chk(input [8*8:1] nm, input [31:0] e, input [31:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e)
      begin
        errors = errors + 1;
        $display("wrong value %0s expected %0h seen %0h", nm, e, g);
      end
    end
  endtask

  // Write: address and data are offered together and each is dropped once taken.
  task wr(input [7:0] a, input [3:0] d, input [1:0] er);
    reg ad, wd;
    begin
      ad = 1'h0;
      wd = 1'h0;
      @(posedge CLK);
      AWADDR <= a;
      WDATA <= {28'h0, d};
      AWVALID <= 1'h1;
      WVALID <= 1'h1;
      BREADY <= 1'h1;
      while (!(ad && wd))
      begin
        @(posedge CLK);
        if (AWVALID && AWREADY)
        begin
          ad = 1'h1;
          AWVALID <= 1'h0;
        end
        if (WVALID && WREADY)
        begin
          wd = 1'h1;
          WVALID <= 1'h0;
        end
      end
      while (BVALID !== 1'h1)
        @(posedge CLK);
      BREADY <= 1'h0;
      chk("bresp", er, BRESP);
      // Registered outputs lag the register by a cycle, so let them settle.
      repeat (2) @(posedge CLK);
    end
  endtask

  // Read: the response code and data are taken at the handshake edge.
  task rdt(input [7:0] a, input [31:0] ed, input [1:0] er);
    begin
      @(posedge CLK);
      ARADDR <= a;
      ARVALID <= 1'h1;
      RREADY <= 1'h1;
      @(posedge CLK);
      while (ARREADY !== 1'h1)
        @(posedge CLK);
      ARVALID <= 1'h0;
      while (RVALID !== 1'h1)
        @(posedge CLK);
      RREADY <= 1'h0;
      chk("rresp", er, RRESP);
      chk("rdata", ed, RDATA);
    end
  endtask

  // Writes a register by index and checks the outputs that it steers.
  task wv(input [3:0] k, input [3:0] d, input [3:0] e);
    begin
      wr({2'h0, k, 2'h0}, d, `CDC_RESP_OKAY);
      chk("outputs", e, grp(k));
    end
  endtask

  task summarize;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  // Main sequence of register scenarios.
  initial
  begin
    repeat (5) @(posedge CLK);
    ARST_N <= 1'h1;
    // Outputs are registered, so give them one full edge after release before looking.
    repeat (2) @(posedge CLK);
    chk("reset", 16'h1171, {grp(4'hA), grp(4'hB), grp(4'hD), 4'h1});
    chk("reset", 12'h402, {grp(4'hE), grp(4'hF), grp(4'hC)});
    chk("reset", 1'h1, MONO_KILL);
    wv(4'hA, 4'h5, 4'h0);
    wv(4'hA, 4'h8, 4'h3);
    wv(4'hA, 4'hD, 4'h2);
    wv(4'hB, 4'h2, 4'h2);
    wv(4'hB, 4'h3, 4'h4);
    wv(4'hB, 4'hB, 4'hC);
    wv(4'hB, 4'h0, 4'h1);
    wv(4'hC, 4'h7, 4'h7);
    wv(4'hC, 4'h8, 4'h8);
    rdt(`CDC_ADDR_STATUS, 32'h24, `CDC_RESP_OKAY);
    wv(4'hD, 4'h0, 4'hD);
    // Move the motor drives so the pins are seen to follow them.
    MOTOR_A_IN <= 1'h0;
    MOTOR_B_IN <= 1'h1;
    repeat (2) @(posedge CLK);
    chk("motor", 4'hE, grp(4'hD));
    wv(4'hD, 4'h5, 4'h2);
    // Drop the de-emphasis indication so pin five is seen to follow it.
    DEEMPH_IN <= 1'h0;
    repeat (2) @(posedge CLK);
    chk("deemph", 4'h0, grp(4'hD));
    wv(4'hD, 4'hA, 4'h4);
    wv(4'hD, 4'hF, 4'h7);
    wv(4'hE, 4'hB, 4'hB);
    wv(4'hE, 4'h4, 4'h4);
    wv(4'hF, 4'hC, 4'hC);
    // In each shadow bank a speed write must land in the bank, not the main register.
    for (i = 1; i < 4; i = i + 1)
    begin
      wv(4'hF, i[3:0], i[3:0]);
      wv(4'hB, 4'h3, 4'h1);
      rdt(8'hAC, 32'h3, `CDC_RESP_OKAY);
      wr(`CDC_ADDR_ESCAPE, 4'h0, `CDC_RESP_OKAY);
      chk("bank", 4'h0, grp(4'hF));
    end
    wr(8'h48, 4'h3, `CDC_RESP_SLVERR);
    wr(8'h2D, 4'h3, `CDC_RESP_SLVERR);
    chk("speed", 4'h1, grp(4'hB));
    rdt(8'h48, 32'h0, `CDC_RESP_SLVERR);
    rdt(8'h2C, 32'h0, `CDC_RESP_OKAY);
    summarize;
  end

  // Cuts a hang short after about 2500 cycles, well past the expected run.
  initial
  begin
    #100000;
    errors = errors + 1;
    summarize;
  end
endmodule
